// ---- adc_sequencer_result_regs_tb.sv ----
`timescale 1ns/1ns
`default_nettype none
module adc_sequencer_result_regs_tb;
    import asr_pkg::*;
    logic                   clk_sys;
    logic                   sys_rst;
    logic                   mstop;
    asr_bus_req_t           bus_req;
    logic [15:0]            bus_rdata;
    logic                   timer_trig;
    logic                   ext_pin;
    logic                   comp_in;
    logic [3:0]             mux;
    logic                   sh;
    logic [RES_W-1:0]       dac;
    logic                   irq;
    logic [15:0][RES_W-1:0] levels;
    logic [15:0]            rd;
    logic [3:0]             seen[$];
    logic                   sh_ok;
    int                     shn;
    int                     n;
    int                     num_errors;
    int                     total_checks;

    asr_conv_ctrl i_asr_conv_ctrl (
        .clk_sys                   (clk_sys),
        .sys_rst                   (sys_rst),
        .converter_module_stop_bit (mstop),
        .bus_req                   (bus_req),
        .bus_rdata                 (bus_rdata),
        .timer_trig                (timer_trig),
        .ext_conv_trigger_pin      (ext_pin),
        .comp_in                   (comp_in),
        .analog_mux_sel            (mux),
        .sample_hold               (sh),
        .dac_code                  (dac),
        .conversion_end_irq        (irq)
    );

    asr_analog_model i_asr_analog_model (
        .clk_sys        (clk_sys),
        .levels         (levels),
        .analog_mux_sel (mux),
        .sample_hold    (sh),
        .dac_code       (dac),
        .comp_in        (comp_in)
    );

    initial
    begin
        clk_sys = 1'h0;
        forever #10 clk_sys = ~clk_sys;
    end

    task automatic tally_and_finish;
        $display("checks %0d errors %0d", total_checks, num_errors);
        if (num_errors == 0 && total_checks > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask

    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        total_checks++;
        if (got !== exp)
        begin
            num_errors++;
            $display("wrong value at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    task automatic wr(input logic [3:0] a, input logic [7:0] d);
        @(posedge clk_sys);
        bus_req <= '{rd: 1'h0, wr: 1'h1, word: 1'h0, addr: a, wdata: d};
        @(posedge clk_sys);
        bus_req <= '0;
    endtask

    // Data lands at the edge that takes the strobe
    task automatic rd16(input logic [3:0] a, input logic w);
        @(posedge clk_sys);
        bus_req <= '{rd: 1'h1, wr: 1'h0, word: w, addr: a, wdata: 8'h00};
        @(posedge clk_sys);
        bus_req <= '0;
        #1;
        rd = bus_rdata;
    endtask

    task automatic wait_irq;
        n = 0;
        while (irq !== 1'h1 && n < 800)
        begin
            @(posedge clk_sys);
            #1;
            n++;
        end
        if (n >= 800)
        begin
            num_errors++;
            tally_and_finish();
        end
    endtask

    // Polling also arms the flag for clearing
    task automatic wait_flag;
        n = 0;
        do
        begin
            rd16(ADDR_CSR, 1'h0);
            n++;
        end
        while (rd[CSR_FLAG] !== 1'h1 && n < 2000);
        if (n >= 2000)
        begin
            num_errors++;
            tally_and_finish();
        end
    endtask

    task automatic fire(input logic [1:0] s);
        @(posedge clk_sys);
        if (s == TRIG_TMR)
            timer_trig <= 1'h1;
        else
            ext_pin <= 1'h1;
        @(posedge clk_sys);
        timer_trig <= 1'h0;
        repeat (3) @(posedge clk_sys);
        ext_pin <= 1'h0;
    endtask

    always @(posedge sh)
        seen.push_back(mux);

    // Aborted samples are skipped, their length is meaningless
    always @(posedge clk_sys)
        if (sh)
            shn <= shn + 1;
        else if (shn != 0)
        begin
            if (sh_ok)
                chk(16'(shn), 16'(SAMPLE_CYC));
            shn <= 0;
        end

    initial
    begin
        repeat (100000) @(posedge clk_sys);
        num_errors++;
        tally_and_finish();
    end

    initial
    begin
        sys_rst = 1'h1;
        mstop = 1'h0;
        bus_req = '0;
        timer_trig = 1'h0;
        ext_pin = 1'h0;
        sh_ok = 1'h1;
        shn = 0;
        num_errors = 0;
        total_checks = 0;
        for (int i = 0; i < 16; i++)
            levels[i] = RES_W'(i * 69);
        levels[15] = 10'h3ff;
        repeat (8) @(posedge clk_sys);
        sys_rst <= 1'h0;
        rd16(ADDR_CSR, 1'h0);
        chk(rd, {8'h00, CSR_RST});
        rd16(ADDR_CR, 1'h0);
        chk(rd, {8'h00, CR_RST});
        rd16(4'ha, 1'h0);
        chk(rd, 16'h0000);
        for (int g = 0; g < 4; g++)
            for (int p = 0; p < 4; p++)
            begin
                wr(ADDR_CSR, 8'h60 | 8'(g << 2) | 8'(p));
                wait_irq();
                chk(16'(n >= CONV_CYC && n <= CONV_CYC + 6), 16'h0001);
                rd16(ADDR_CSR, 1'h0);
                chk(rd, 16'h00c0 | 16'(g << 2) | 16'(p));
                wr(4'(2 * p), 8'hff);
                rd16(4'(2 * p), 1'h1);
                chk(rd, {levels[4 * g + p], 6'h00});
                rd16(4'(2 * p), 1'h0);
                chk(rd, {8'h00, levels[4 * g + p][9:2]});
                rd16(4'(2 * p + 1), 1'h0);
                chk(rd, {8'h00, levels[4 * g + p][1:0], 6'h00});
                wr(ADDR_CSR, 8'h40);
                rd16(ADDR_CSR, 1'h0);
                chk({15'h0000, irq}, 16'h0000);
            end
        wr(ADDR_CSR, 8'h20);
        wait_flag();
        chk({15'h0000, irq}, 16'h0000);
        for (int i = 8; i < 12; i++)
            levels[i] = RES_W'(10'h2a5 - i * 3);
        seen.delete();
        wr(ADDR_CSR, 8'h3b);
        wait_flag();
        chk(rd, 16'h00bb);
        for (int k = 0; k < 4; k++)
        begin
            chk(16'(seen[k]), 16'(8 + k));
            rd16(4'(2 * k), 1'h1);
            chk(rd, {levels[8 + k], 6'h00});
        end
        wr(ADDR_CSR, 8'h3b);
        wait_flag();
        chk(16'(seen.size() >= 8 && seen[4] == 4'h8), 16'h0001);
        sh_ok = 1'h0;
        wr(ADDR_CSR, 8'h1b);
        repeat (2) @(posedge clk_sys);
        seen.delete();
        repeat (700) @(posedge clk_sys);
        chk(16'(seen.size()), 16'h0000);
        rd16(ADDR_CSR, 1'h0);
        chk(rd, 16'h001b);
        sh_ok = 1'h1;
        for (int t = 1; t < 3; t++)
        begin
            levels[4] = RES_W'(10'h1c7 + t * 100);
            wr(ADDR_CR, 8'(t));
            wr(ADDR_CSR, 8'h44);
            seen.delete();
            fire(t == 1 ? TRIG_EXT : TRIG_TMR);
            repeat (20) @(posedge clk_sys);
            chk(16'(seen.size()), 16'h0000);
            fire(2'(t));
            wait_irq();
            rd16(4'h0, 1'h1);
            chk(rd, {levels[4], 6'h00});
            wr(ADDR_CSR, 8'h44);
            rd16(ADDR_CSR, 1'h0);
            chk(rd, 16'h00c4);
            wr(ADDR_CSR, 8'h44);
        end
        wr(ADDR_CSR, 8'h60);
        repeat (300) @(posedge clk_sys);
        mstop <= 1'h1;
        repeat (3) @(posedge clk_sys);
        mstop <= 1'h0;
        rd16(ADDR_CSR, 1'h0);
        chk(rd, 16'h0000);
        rd16(ADDR_CR, 1'h0);
        chk({rd[15:1], sh}, 16'h0000);
        tally_and_finish();
    end
endmodule // adc_sequencer_result_regs_tb
`default_nettype wire

// ---- asr_analog_model.sv ----
`timescale 1ns/1ns
`default_nettype none
module asr_analog_model
    import asr_pkg::*;
(
    // System
    input  wire logic                   clk_sys,
    // Analog front end
    input  wire logic [15:0][RES_W-1:0] levels,
    input  wire logic [3:0]             analog_mux_sel,
    input  wire logic                   sample_hold,
    input  wire logic [RES_W-1:0]       dac_code,
    output logic                        comp_in
);
    logic [RES_W-1:0] held = '0;

    // Input number is group times four plus position
    always_ff @(posedge clk_sys)
        if (sample_hold)
            held <= levels[analog_mux_sel];

    // Ideal comparator; the held value never drifts
    assign comp_in = (held >= dac_code);
endmodule // asr_analog_model
`default_nettype wire

// ---- asr_conv_ctrl.sv ----
// How it works
// - Each 10-bit result sits left-justified in bits 15..6 of its register.
// - Bits 5..0 of every result register always read as zero.
// - Four read-only 16-bit result registers, one per position in the group.
// - Bus carries 8 bits per byte access; results split upper and lower.
// - Upper-byte read copies lower byte to a latch; lower reads return it.
// - Sixteen inputs form four groups of four consecutive inputs.
// - Two select bits pick the group; position n lands in register n.
// - Single mode converts the selected channel once per start.
// - Scan mode repeats over one to four channels without new starts.
// - Starts come from software, the timer unit, or the external trigger.
// - A dedicated trigger pin starts conversion when selected.
// - A conversion-end interrupt request can be raised.
// - Each channel conversion takes the fixed documented cycle count.
// - Each channel is sampled and held before bit decisions.
// - Module stop halts the block and resets the controller; the engine goes idle but holds dac_code.
// - End flag sets on conversion or pass end; cleared by 0 after reading 1.
// - Start bit self-clears in single mode; scan runs until cleared.
// - Mode bit 0 selects single, 1 selects scan.
// - Interrupt request only while the enable bit is 1.
`timescale 1ns/1ns
`default_nettype none
module asr_conv_ctrl
    import asr_pkg::*;
(
    // System
    input  wire logic             clk_sys,
    input  wire logic             sys_rst,
    input  wire logic             converter_module_stop_bit,
    // Processor byte bus
    input  wire asr_bus_req_t     bus_req,
    output logic [15:0]           bus_rdata,
    // Start sources
    input  wire logic             timer_trig,
    input  wire logic             ext_conv_trigger_pin,
    // Analog front end
    input  wire logic             comp_in,
    output logic [3:0]            analog_mux_sel,
    output logic                  sample_hold,
    output logic [RES_W-1:0]      dac_code,
    // Interrupt
    output logic                  conversion_end_irq
);
    asr_ctl_t         st;
    asr_ctl_t         next_st;
    logic             eng_done;
    logic [RES_W-1:0] eng_result;
    logic             res_addr;
    logic [15:0]      word_src;
    logic [7:0]       low_src;

    asr_sar_engine u_engine (
        .clk_sys     (clk_sys),
        .sys_rst     (sys_rst),
        .start       (st.go),
        .abort       (!st.start),
        .done        (eng_done),
        .result      (eng_result),
        .comp_in     (comp_in),
        .sample_hold (sample_hold),
        .dac_code    (dac_code)
    );

    function automatic logic is_res(input logic [3:0] a);
        return a <= ADDR_RES_LAST;
    endfunction

    assign res_addr = is_res(bus_req.addr);
    assign word_src = {st.res[bus_req.addr[2:1]], 6'h00};
    assign low_src = word_src[7:0];

    always_comb
    begin
        logic trig_ev;
        logic launch;
        logic last;
        trig_ev = 1'b0;
        launch = 1'b0;
        last = 1'b0;
        next_st = st;
        next_st.go = 1'b0;
        next_st.ext_s1 = ext_conv_trigger_pin;
        next_st.ext_s2 = st.ext_s1;
        next_st.ext_d = st.ext_s2;

        // Hardware start sources, ignored while already running
        if (st.trig == TRIG_TMR && timer_trig)
            trig_ev = 1'b1;
        if (st.trig == TRIG_EXT && st.ext_s2 && !st.ext_d)
            trig_ev = 1'b1;
        if (!st.start && trig_ev)
            launch = 1'b1;

        // Register reads; the byte path is 8 bits, word reads use all 16
        if (bus_req.rd)
        begin
            next_st.rdata = 16'h0000;
            if (bus_req.addr == ADDR_CSR)
            begin
                next_st.rdata[7:0] = {st.flag, st.ie, st.start, st.scan, st.grp, st.chn};
                if (st.flag)
                    next_st.armed = 1'b1;
            end
            else if (bus_req.addr == ADDR_CR)
                next_st.rdata[1:0] = st.trig;
            else if (res_addr && bus_req.word)
                next_st.rdata = word_src;
            else if (res_addr && !bus_req.addr[0])
            begin
                next_st.rdata[7:0] = word_src[15:8];
                next_st.temp = low_src;
            end
            else if (res_addr)
                next_st.rdata[7:0] = st.temp;
        end

        // Register writes; result registers ignore writes
        if (bus_req.wr && bus_req.addr == ADDR_CSR)
        begin
            next_st.ie = bus_req.wdata[CSR_IE];
            next_st.scan = bus_req.wdata[CSR_SCAN];
            next_st.grp = bus_req.wdata[CSR_GRP +: 2];
            next_st.chn = bus_req.wdata[CSR_CHN +: 2];
            if (bus_req.wdata[CSR_START] && !st.start)
                launch = 1'b1;
            if (!bus_req.wdata[CSR_START])
            begin
                next_st.start = 1'b0;
                next_st.busy = 1'b0;
            end
            if (!bus_req.wdata[CSR_FLAG] && st.armed)
            begin
                next_st.flag = 1'b0;
                next_st.armed = 1'b0;
            end
        end
        if (bus_req.wr && bus_req.addr == ADDR_CR)
            next_st.trig = bus_req.wdata[CR_TRIG +: 2];

        // Conversion end: store, then step or finish; set beats clear
        if (eng_done && st.start)
        begin
            next_st.res[st.cur] = eng_result;
            next_st.busy = 1'b0;
            last = !st.scan || st.cur == st.chn;
            if (last)
            begin
                next_st.flag = 1'b1;
                next_st.armed = 1'b0;
            end
            if (!st.scan)
                next_st.start = 1'b0;
            else if (last)
                next_st.cur = 2'h0;
            else
                next_st.cur = st.cur + 2'h1;
        end

        if (launch)
        begin
            next_st.start = 1'b1;
            next_st.busy = 1'b0;
            next_st.cur = next_st.scan ? 2'h0 : next_st.chn;
        end

        // Hand the next channel to the engine once it is free
        if (next_st.start && !next_st.busy && !st.go)
        begin
            next_st.go = 1'b1;
            next_st.busy = 1'b1;
            next_st.mux = {next_st.grp, next_st.cur};
        end

        next_st.irq = next_st.flag && next_st.ie;

        // Module stop: everything back to reset, only the pin sync runs
        if (converter_module_stop_bit)
        begin
            next_st = '0;
            next_st.ext_s1 = ext_conv_trigger_pin;
            next_st.ext_s2 = st.ext_s1;
            next_st.ext_d = st.ext_s2;
        end
    end

    always_ff @(posedge clk_sys)
    begin
        if (sys_rst)
        begin
            st <= '0;
            st.ie <= CSR_RST[CSR_IE];
            st.trig <= CR_RST[1:0];
        end
        else
            st <= next_st;
    end

    assign bus_rdata = st.rdata;
    assign analog_mux_sel = st.mux;
    assign conversion_end_irq = st.irq;

    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (sys_rst);

    a_word_read_coherent: assert property (
        (bus_req.rd && bus_req.word && res_addr && !converter_module_stop_bit)
        |=> bus_rdata == $past(word_src))
        else $error("word read not coherent");
    a_low_six_zero: assert property (
        (bus_req.rd && bus_req.word && res_addr) |=> bus_rdata[5:0] == 6'h00)
        else $error("low result bits not zero");
    a_upper_fills_latch: assert property (
        (bus_req.rd && !bus_req.word && res_addr && !bus_req.addr[0]
         && !converter_module_stop_bit) |=> st.temp == $past(low_src))
        else $error("latch not loaded on upper read");
    a_lower_from_latch: assert property (
        (bus_req.rd && !bus_req.word && res_addr && bus_req.addr[0]
         && !converter_module_stop_bit) |=> bus_rdata == {8'h00, $past(st.temp)})
        else $error("lower read not from latch");
    a_single_clears_start: assert property (
        (eng_done && st.start && !st.scan && !converter_module_stop_bit
         && !(bus_req.wr && bus_req.addr == ADDR_CSR)) |=> !st.start)
        else $error("start not cleared in single mode");
    a_flag_on_end: assert property (
        (eng_done && st.start && (!st.scan || st.cur == st.chn)
         && !converter_module_stop_bit) |=> st.flag ##1 (st.flag || $past(bus_req.wr)))
        else $error("end flag not set");
    a_irq_gate: assert property (
        conversion_end_irq == (st.flag && st.ie))
        else $error("interrupt not gated by enable");
    a_scan_order: assert property (
        (eng_done && st.start && st.scan && st.cur != st.chn
         && !converter_module_stop_bit && !bus_req.wr) |=> st.cur == $past(st.cur) + 2'h1)
        else $error("scan order broken");
    a_stop_halts: assert property (
        converter_module_stop_bit |=> !st.start && !st.busy && !conversion_end_irq)
        else $error("module stop did not halt");
    a_group_select: assert property (
        st.go |-> analog_mux_sel == {st.grp, st.cur} ##1 sample_hold)
        else $error("mux select wrong at launch");

    // Byte path and read-only results
    a_byte_upper_zero: assert property (
        (bus_req.rd && !bus_req.word && res_addr)
        |=> bus_rdata[15:8] == 8'h00)
        else $error("byte read upper half not zero");
    a_upper_byte_value: assert property (
        (bus_req.rd && !bus_req.word && res_addr && !bus_req.addr[0]
         && !converter_module_stop_bit)
        |=> bus_rdata[7:0] == $past(st.res[bus_req.addr[2:1]][9:2]))
        else $error("upper byte not left-justified result");
    a_result_read_only: assert property (
        (bus_req.wr && res_addr && !eng_done && !converter_module_stop_bit)
        |=> $stable(st.res))
        else $error("result register took a write");

    // Launch and sequencing; stop excluded in all but a_stop_clears_regs, register writes only where they override
    a_timer_launch: assert property (
        (st.trig == TRIG_TMR && timer_trig && !st.start && !converter_module_stop_bit)
        |=> st.start && st.go)
        else $error("timer trigger did not start");
    a_ext_launch: assert property (
        (st.trig == TRIG_EXT && st.ext_s2 && !st.ext_d && !st.start
         && !converter_module_stop_bit)
        |=> st.start && st.go)
        else $error("external trigger did not start");
    a_busy_ignores_trig: assert property (
        (st.start && st.busy && (timer_trig || (st.ext_s2 && !st.ext_d)) && !eng_done
         && !bus_req.wr && !converter_module_stop_bit)
        |=> !st.go)
        else $error("trigger accepted while converting");
    a_single_stores: assert property (
        (eng_done && st.start && !st.scan && !converter_module_stop_bit)
        |=> !st.go && st.res[$past(st.cur)] == $past(eng_result))
        else $error("single result not stored once");
    a_scan_continues: assert property (
        (eng_done && st.start && st.scan && !converter_module_stop_bit
         && !(bus_req.wr && bus_req.addr == ADDR_CSR))
        |=> st.start && st.go)
        else $error("scan did not continue");
    a_scan_wraps: assert property (
        (eng_done && st.start && st.scan && st.cur == st.chn
         && !converter_module_stop_bit)
        |=> st.cur == 2'h0)
        else $error("scan did not wrap to first channel");
    a_mode_bit: assert property (
        (bus_req.wr && bus_req.addr == ADDR_CSR && !converter_module_stop_bit)
        |=> st.scan == $past(bus_req.wdata[CSR_SCAN]))
        else $error("mode bit not taken");
    a_flag_needs_read: assert property (
        (st.flag && !st.armed && !converter_module_stop_bit) |=> st.flag)
        else $error("flag cleared without prior read");
    a_irq_on_end: assert property (
        (eng_done && st.start && st.ie && (!st.scan || st.cur == st.chn)
         && !bus_req.wr && !converter_module_stop_bit)
        |=> conversion_end_irq)
        else $error("no interrupt at conversion end");
    a_stop_clears_regs: assert property (
        converter_module_stop_bit |=> !st.flag && st.trig == 2'h0 && bus_rdata == 16'h0000)
        else $error("module stop left register state");

    c_single_done: cover property (eng_done && st.start && !st.scan);
    c_scan_wrap: cover property (eng_done && st.scan && st.cur == st.chn && st.chn == 2'h3);
    c_ext_launch: cover property (st.trig == TRIG_EXT && st.ext_s2 && !st.ext_d && !st.start);
    c_word_read: cover property (bus_req.rd && bus_req.word && res_addr && st.flag);
    c_timer_launch: cover property (st.trig == TRIG_TMR && timer_trig && !st.start);
endmodule // asr_conv_ctrl
`default_nettype wire

// ---- asr_pkg.sv ----
`default_nettype none
package asr_pkg;
    // Timing
    localparam int CLK_MHZ      = 50;
    localparam int CONV_TIME_NS = 11080;
    localparam int CONV_CYC     = (CONV_TIME_NS * CLK_MHZ + 999) / 1000;
    localparam int BIT_CYC      = 40;
    localparam int SAMPLE_CYC   = CONV_CYC - 10 * BIT_CYC;
    localparam int RES_W        = 10;
    localparam int RES_LSB      = 6;

    // Byte addresses: result n upper byte at 2n, lower byte at 2n+1
    localparam logic [3:0] ADDR_RES_LAST = 4'h7;
    localparam logic [3:0] ADDR_CSR      = 4'h8;
    localparam logic [3:0] ADDR_CR       = 4'h9;

    // Control/status fields
    localparam int CSR_FLAG  = 7;
    localparam int CSR_IE    = 6;
    localparam int CSR_START = 5;
    localparam int CSR_SCAN  = 4;
    localparam int CSR_GRP   = 2;
    localparam int CSR_CHN   = 0;
    localparam int CR_TRIG   = 0;
    localparam logic [7:0] CSR_RST = 8'h00;
    localparam logic [7:0] CR_RST  = 8'h00;

    // Trigger source select
    localparam logic [1:0] TRIG_SW  = 2'h0;
    localparam logic [1:0] TRIG_TMR = 2'h1;
    localparam logic [1:0] TRIG_EXT = 2'h2;

    typedef struct packed {
        logic       rd;
        logic       wr;
        logic       word;
        logic [3:0] addr;
        logic [7:0] wdata;
    } asr_bus_req_t;

    typedef enum logic [1:0] {
        E_IDLE   = 2'b00,
        E_SAMPLE = 2'b01,
        E_BIT    = 2'b10
    } asr_eng_state_t;

    typedef struct packed {
        asr_eng_state_t   st;
        logic [9:0]       cnt;
        logic [3:0]       bitn;
        logic [RES_W-1:0] code;
        logic [RES_W-1:0] result;
        logic             done;
        logic             sh;
        logic             comp_s1;
        logic             comp_s2;
    } asr_eng_t;

    typedef struct packed {
        logic                       flag;
        logic                       armed;
        logic                       ie;
        logic                       start;
        logic                       scan;
        logic [1:0]                 grp;
        logic [1:0]                 chn;
        logic [1:0]                 trig;
        logic [1:0]                 cur;
        logic                       busy;
        logic                       go;
        logic [3:0][RES_W-1:0]      res;
        logic [7:0]                 temp;
        logic [15:0]                rdata;
        logic                       irq;
        logic                       ext_s1;
        logic                       ext_s2;
        logic                       ext_d;
        logic [3:0]                 mux;
    } asr_ctl_t;
endpackage
`default_nettype wire

// ---- asr_sar_engine.sv ----
`timescale 1ns/1ns
`default_nettype none
module asr_sar_engine
    import asr_pkg::*;
(
    // System
    input  wire logic             clk_sys,
    input  wire logic             sys_rst,
    // Sequencer side
    input  wire logic             start,
    input  wire logic             abort,
    output logic                  done,
    output logic [RES_W-1:0]      result,
    // Analog side
    input  wire logic             comp_in,
    output logic                  sample_hold,
    output logic [RES_W-1:0]      dac_code
);
    asr_eng_t st;
    asr_eng_t next_st;
    logic [10:0] run_len;

    always_comb
    begin
        logic [RES_W-1:0] nc;
        nc = st.code;
        next_st = st;
        next_st.done = 1'b0;
        next_st.comp_s1 = comp_in;
        next_st.comp_s2 = st.comp_s1;
        case (st.st)
            E_IDLE:
            begin
                if (start && !abort)
                begin
                    next_st.st = E_SAMPLE;
                    next_st.sh = 1'b1;
                    next_st.cnt = 10'(SAMPLE_CYC - 1);
                end
            end
            E_SAMPLE:
            begin
                if (abort)
                begin
                    next_st.st = E_IDLE;
                    next_st.sh = 1'b0;
                end
                else if (st.cnt == 10'h000)
                begin
                    next_st.st = E_BIT;
                    next_st.sh = 1'b0;
                    next_st.bitn = 4'h9;
                    next_st.code = 10'h200;
                    next_st.cnt = 10'(BIT_CYC - 1);
                end
                else
                    next_st.cnt = st.cnt - 10'h001;
            end
            E_BIT:
            begin
                if (abort)
                    next_st.st = E_IDLE;
                else if (st.cnt == 10'h000)
                begin
                    // Comparator low: trial level overshot the input
                    if (!st.comp_s2)
                        nc[st.bitn] = 1'b0;
                    if (st.bitn == 4'h0)
                    begin
                        next_st.result = nc;
                        next_st.done = 1'b1;
                        next_st.st = E_IDLE;
                    end
                    else
                    begin
                        nc[st.bitn - 4'h1] = 1'b1;
                        next_st.bitn = st.bitn - 4'h1;
                        next_st.cnt = 10'(BIT_CYC - 1);
                    end
                    next_st.code = nc;
                end
                else
                    next_st.cnt = st.cnt - 10'h001;
            end
            default:
                next_st.st = E_IDLE;
        endcase
    end

    always_ff @(posedge clk_sys)
    begin
        if (sys_rst)
            st <= '0;
        else
            st <= next_st;
    end

    // Cycles spent outside idle, for checking only
    always_ff @(posedge clk_sys)
    begin
        if (sys_rst || st.st == E_IDLE)
            run_len <= 11'h000;
        else
            run_len <= run_len + 11'h001;
    end

    assign done = st.done;
    assign result = st.result;
    assign sample_hold = st.sh;
    assign dac_code = st.code;

    a_conv_length: assert property (@(posedge clk_sys) disable iff (sys_rst)
        st.done |-> run_len == 11'(CONV_CYC))
        else $error("conversion length wrong");
    a_sample_phase: assert property (@(posedge clk_sys) disable iff (sys_rst)
        (st.st == E_IDLE && start && !abort) |=> sample_hold && st.st == E_SAMPLE)
        else $error("sampling phase missing");
endmodule // asr_sar_engine
`default_nettype wire
